// File: pll_clock_mode_select.sv
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "pll_clock_mode_select_defines.svh"

module pll_clock_mode_select (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [`REG_ADDR_W-1:0] I_ADDR,
  input wire logic [`REG_DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [`REG_DATA_W-1:0] O_RDATA,
  input wire logic I_PLL_SUPPLY_STRAP,
  input wire logic I_RESET_PIN_B,
  input wire logic I_HALT_PIN_B,
  input wire logic I_CORE_DISABLE_MODE,
  input wire logic I_CLOCK_MODE_SELECT_I,
  output logic O_CLOCK_MODE_SELECT_O,
  output logic O_CLOCK_MODE_SELECT_OE,
  input wire logic I_PORT_A_BIT_TWELVE_OUT,
  input wire logic I_PORT_A_BIT_TWELVE_OE,
  output logic O_PORT_A_BIT_TWELVE_IN,
  input wire logic I_CRYSTAL_CLOCK_INPUT,
  output logic O_CRYSTAL_DRIVE_OUTPUT,
  input wire logic I_PLL_CLOCK,
  output logic O_PLL_ENABLE,
  output logic [`MULT_W-1:0] O_MULTIPLICATION_FACTOR,
  output logic O_SYSTEM_CLOCK_OUTPUT,
  output logic O_SYSTEM_CLOCK_OE,
  output logic [`DRIVE_W-1:0] O_SYSTEM_CLOCK_DRIVE,
  output logic O_CORE_CLOCK,
  output logic O_COMMUNICATION_PROCESSOR_CLOCK,
  output logic O_INTEGRATION_CLOCK,
  input wire logic I_INT_AS,
  input wire logic [`EXT_ADDR_W-1:0] I_INT_ADDR,
  output logic [`EXT_ADDR_W-1:0] O_EXT_ADDR,
  output logic O_EXT_AS_B,
  output logic O_EXT_BUS_OE,
  input wire logic I_EXT_AS_B,
  input wire logic [`EXT_ADDR_W-1:0] I_EXT_ADDR,
  output logic O_SEEN_VALID,
  output logic [`EXT_ADDR_W-1:0] O_SEEN_ADDR,
  output logic O_CHIP_SELECT_B,
  output logic O_TRANSFER_ACKNOWLEDGE_B
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic total_reset;
  logic pll_en;
  logic mode_q;
  logic core_dis;
  logic locked;
  logic gpio_mode;

  pll_clock_mode_select_pkg::drive_t drive_q, drive_d;
  logic [`MULT_W-1:0] mult_q, mult_d;
  logic [`MULT_W-1:0] mult_default;
  logic [`EXT_ADDR_W-1:0] cs_base_q, cs_base_d;
  logic [`EXT_ADDR_W-1:0] cs_mask_q, cs_mask_d;
  logic cs_en_q, cs_en_d;

  logic wr_clk_ctrl;
  logic wr_mult;
  logic wr_cs_base;
  logic wr_cs_mask;
  logic wr_cs_ctrl;
  logic [`REG_DATA_W-1:0] rd_val;
  logic [`STAT_W-1:0] status;

  logic clk_src;
  logic drive_on;
  logic int_master;

  ////////////////////////////////////////////////////////////////////////////
  // total system reset and configuration capture

  // total reset needs reset and halt pins asserted together
  assign total_reset = !I_RESET_PIN_B && !I_HALT_PIN_B;

  cfg_sampler u_cfg_sampler (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_total_reset(total_reset),
    .i_strap(I_PLL_SUPPLY_STRAP),
    .i_mode_pin(I_CLOCK_MODE_SELECT_I),
    .i_core_dis_pin(I_CORE_DISABLE_MODE),
    .o_pll_en(pll_en),
    .o_mode(mode_q),
    .o_core_dis(core_dis),
    .o_locked(locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  // one-hot write enables, unmapped writes fall through unused
  assign wr_clk_ctrl = I_WR && (I_ADDR == `REG_CLK_CTRL);
  assign wr_mult = I_WR && (I_ADDR == `REG_MULT);
  assign wr_cs_base = I_WR && (I_ADDR == `REG_CS_BASE);
  assign wr_cs_mask = I_WR && (I_ADDR == `REG_CS_MASK);
  assign wr_cs_ctrl = I_WR && (I_ADDR == `REG_CS_CTRL);

  // status shows the captured straps and whether the pin was released
  assign status = {locked, core_dis, mode_q, pll_en};

  // read select, unmapped and reserved bits read zero
  always_comb begin
    rd_val = '0;
    if (I_ADDR == `REG_CLK_CTRL) begin
      rd_val[`DRIVE_W-1:0] = drive_q;
    end else if (I_ADDR == `REG_MULT) begin
      rd_val[`MULT_W-1:0] = mult_q;
    end else if (I_ADDR == `REG_STATUS) begin
      rd_val[`STAT_W-1:0] = status;
    end else if (I_ADDR == `REG_CS_BASE) begin
      rd_val[`EXT_ADDR_W-1:0] = cs_base_q;
    end else if (I_ADDR == `REG_CS_MASK) begin
      rd_val[`EXT_ADDR_W-1:0] = cs_mask_q;
    end else if (I_ADDR == `REG_CS_CTRL) begin
      rd_val[`CS_EN_BIT] = cs_en_q;
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= '0;
    end else begin
      O_RDATA <= I_RD ? rd_val : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  // default factor follows the sampled mode pin
  assign mult_default = mode_q ? `MULT_KHZ_CRYSTAL :
    `MULT_MHZ_CRYSTAL;

  // total reset wins over software so the default is back afterwards
  assign drive_d = total_reset ? pll_clock_mode_select_pkg::drive_t'(
    `DRIVE_RESET) : (wr_clk_ctrl ? pll_clock_mode_select_pkg::drive_t'(
    I_WDATA[`DRIVE_LSB +: `DRIVE_W]) : drive_q);
  assign mult_d = !locked ? mult_default :
    (wr_mult ? I_WDATA[`MULT_W-1:0] : mult_q);
  assign cs_base_d = wr_cs_base ? I_WDATA[`EXT_ADDR_W-1:0] : cs_base_q;
  assign cs_mask_d = wr_cs_mask ? I_WDATA[`EXT_ADDR_W-1:0] : cs_mask_q;
  assign cs_en_d = total_reset ? 1'b0 :
    (wr_cs_ctrl ? I_WDATA[`CS_EN_BIT] : cs_en_q);

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      drive_q <= pll_clock_mode_select_pkg::drive_t'(`DRIVE_RESET);
      mult_q <= `MULT_MHZ_CRYSTAL;
    end else begin
      drive_q <= drive_d;
      mult_q <= mult_d;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cs_base_q <= `CS_BASE_RESET;
      cs_mask_q <= `CS_MASK_RESET;
      cs_en_q <= 1'b0;
    end else begin
      cs_base_q <= cs_base_d;
      cs_mask_q <= cs_mask_d;
      cs_en_q <= cs_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode pin / port a bit twelve sharing

  // strap read live: the captured copy is not valid yet during sampling
  assign gpio_mode = !I_PLL_SUPPLY_STRAP || locked;

  // port stops driving one cycle after total reset asserts; pin stays an input there
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CLOCK_MODE_SELECT_O <= 1'b0;
      O_CLOCK_MODE_SELECT_OE <= 1'b0;
      O_PORT_A_BIT_TWELVE_IN <= 1'b0;
    end else begin
      O_CLOCK_MODE_SELECT_O <= I_PORT_A_BIT_TWELVE_OUT;
      O_CLOCK_MODE_SELECT_OE <= gpio_mode && !total_reset &&
        I_PORT_A_BIT_TWELVE_OE;
      O_PORT_A_BIT_TWELVE_IN <= I_CLOCK_MODE_SELECT_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock generation

  // bypass takes the crystal clock as is, no factor applied
  assign clk_src = pll_en ? I_PLL_CLOCK : I_CRYSTAL_CLOCK_INPUT;
  assign drive_on = (drive_q != pll_clock_mode_select_pkg::DRIVE_OFF);

  // oscillator inverts the crystal at its own rate, nothing divided
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CRYSTAL_DRIVE_OUTPUT <= 1'b0;
    end else begin
      O_CRYSTAL_DRIVE_OUTPUT <= !I_CRYSTAL_CLOCK_INPUT;
    end
  end

  // factor seen by the synthesizer; bypass reports unity
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PLL_ENABLE <= 1'b0;
      O_MULTIPLICATION_FACTOR <= `MULT_BYPASS;
    end else begin
      O_PLL_ENABLE <= pll_en;
      O_MULTIPLICATION_FACTOR <= pll_en ? mult_q : `MULT_BYPASS;
    end
  end

  // pin drive may be off; internal clocks keep running regardless
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SYSTEM_CLOCK_OUTPUT <= 1'b0;
      O_SYSTEM_CLOCK_OE <= 1'b0;
      O_SYSTEM_CLOCK_DRIVE <= `DRIVE_RESET;
    end else begin
      O_SYSTEM_CLOCK_OUTPUT <= clk_src && drive_on;
      O_SYSTEM_CLOCK_OE <= drive_on;
      O_SYSTEM_CLOCK_DRIVE <= drive_q;
    end
  end

  // same edge for core, comm processor and integration logic: no skew
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CORE_CLOCK <= 1'b0;
      O_COMMUNICATION_PROCESSOR_CLOCK <= 1'b0;
      O_INTEGRATION_CLOCK <= 1'b0;
    end else begin
      O_CORE_CLOCK <= clk_src;
      O_COMMUNICATION_PROCESSOR_CLOCK <= clk_src;
      O_INTEGRATION_CLOCK <= clk_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared bus visibility

  // internal master owns the pins unless the core is disabled or total reset is held
  assign int_master = !core_dis && !total_reset;

  // every internal access, dual-port ram too, goes out on the pins while the internal master owns them
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_EXT_ADDR <= '0;
      O_EXT_AS_B <= 1'b1;
      O_EXT_BUS_OE <= 1'b0;
    end else begin
      O_EXT_ADDR <= I_INT_ADDR;
      O_EXT_AS_B <= !(I_INT_AS && int_master);
      O_EXT_BUS_OE <= int_master;
    end
  end

  // pins are watched whoever drives them, so both kinds are seen
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SEEN_VALID <= 1'b0;
      O_SEEN_ADDR <= '0;
    end else begin
      O_SEEN_VALID <= !I_EXT_AS_B;
      O_SEEN_ADDR <= I_EXT_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip select for an external master

  cs_decoder u_cs_decoder (
    .i_clk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_enable(core_dis && cs_en_q),
    .i_as_b(I_EXT_AS_B),
    .i_addr(I_EXT_ADDR),
    .i_base(cs_base_q),
    .i_mask(cs_mask_q),
    .o_cs_b(O_CHIP_SELECT_B),
    .o_ack_b(O_TRANSFER_ACKNOWLEDGE_B)
  );

endmodule

// File: pll_clock_mode_select_defines.svh
`ifndef PLL_CLOCK_MODE_SELECT_DEFINES_SVH
`define PLL_CLOCK_MODE_SELECT_DEFINES_SVH

// register port geometry
`define REG_ADDR_W 8
`define REG_DATA_W 32

// register byte offsets
`define REG_CLK_CTRL 8'h00
`define REG_MULT 8'h04
`define REG_STATUS 8'h08
`define REG_CS_BASE 8'h0c
`define REG_CS_MASK 8'h10
`define REG_CS_CTRL 8'h14

// clock control fields and reset values
`define DRIVE_W 2
`define DRIVE_LSB 0
`define DRIVE_RESET 2'h3

// default multiplication factors; bypass reports unity
`define MULT_W 9
`define MULT_MHZ_CRYSTAL 9'h004
`define MULT_KHZ_CRYSTAL 9'h191
`define MULT_BYPASS 9'h001

// status bit positions
`define STAT_PLL_EN 0
`define STAT_MODE 1
`define STAT_CORE_DIS 2
`define STAT_LOCKED 3
`define STAT_W 4

// chip-select window
`define EXT_ADDR_W 19
`define CS_BASE_RESET 19'h00000
`define CS_MASK_RESET 19'h00000
`define CS_EN_BIT 0

// timing: mode pin hold after total reset negates
`define CLK_PERIOD_NS 10
`define MODE_HOLD_NS 5
`define MODE_HOLD_CYC ((`MODE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CNT_W 4

`endif

// File: pll_clock_mode_select_pkg.sv
package pll_clock_mode_select_pkg;

  // drive strength of the system clock output pin
  typedef enum logic [1:0] {
    DRIVE_OFF = 2'h0,
    DRIVE_THIRD = 2'h1,
    DRIVE_TWO_THIRDS = 2'h2,
    DRIVE_FULL = 2'h3
  } drive_t;

  // configuration sampler states, one-hot
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_LOCKED = 3'b100
  } sample_state_t;

endpackage

// File: cfg_sampler.sv
`timescale 1ns/1ps
`include "pll_clock_mode_select_defines.svh"

module cfg_sampler (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_total_reset,
  input wire logic i_strap,
  input wire logic i_mode_pin,
  input wire logic i_core_dis_pin,
  output logic o_pll_en,
  output logic o_mode,
  output logic o_core_dis,
  output logic o_locked
);

  pll_clock_mode_select_pkg::sample_state_t state_q, state_d;
  logic [`HOLD_CNT_W-1:0] hold_q, hold_d;
  logic capture;
  logic hold_done;

  // keep capturing while reset and halt are both asserted
  assign capture = i_total_reset && (state_q ==
    pll_clock_mode_select_pkg::ST_SAMPLE);
  assign hold_done = (hold_q >= `HOLD_CNT_W'(`MODE_HOLD_CYC));

  // sequence: sample, cover pin hold time, then lock until next total reset
  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    case (state_q)
      pll_clock_mode_select_pkg::ST_SAMPLE: begin
        hold_d = '0;
        if (!i_total_reset) begin
          state_d = pll_clock_mode_select_pkg::ST_HOLD;
        end
      end
      pll_clock_mode_select_pkg::ST_HOLD: begin
        hold_d = hold_q + `HOLD_CNT_W'(1);
        if (i_total_reset) begin
          state_d = pll_clock_mode_select_pkg::ST_SAMPLE;
        end else if (hold_done) begin
          state_d = pll_clock_mode_select_pkg::ST_LOCKED;
        end
      end
      pll_clock_mode_select_pkg::ST_LOCKED: begin
        if (i_total_reset) begin
          state_d = pll_clock_mode_select_pkg::ST_SAMPLE;
        end
      end
      default: begin
        state_d = pll_clock_mode_select_pkg::ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= pll_clock_mode_select_pkg::ST_SAMPLE;
      hold_q <= '0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
    end
  end

  // straps held from the last sampled cycle; bypass ignores the mode pin
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pll_en <= 1'b0;
      o_mode <= 1'b0;
      o_core_dis <= 1'b0;
    end else if (capture) begin
      o_pll_en <= i_strap;
      o_mode <= i_strap & i_mode_pin;
      o_core_dis <= i_core_dis_pin;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_locked <= 1'b0;
    end else begin
      o_locked <= (state_d == pll_clock_mode_select_pkg::ST_LOCKED);
    end
  end

endmodule

// File: cs_decoder.sv
`timescale 1ns/1ps
`include "pll_clock_mode_select_defines.svh"

module cs_decoder (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_as_b,
  input wire logic [`EXT_ADDR_W-1:0] i_addr,
  input wire logic [`EXT_ADDR_W-1:0] i_base,
  input wire logic [`EXT_ADDR_W-1:0] i_mask,
  output logic o_cs_b,
  output logic o_ack_b
);

  logic hit;

  // mask bit set means the address bit takes part in the compare
  assign hit = i_enable && !i_as_b &&
    ((i_addr & i_mask) == (i_base & i_mask));

  // chip select answers in the cycle after the strobe is seen
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cs_b <= 1'b1;
      o_ack_b <= 1'b1;
    end else begin
      o_cs_b <= !hit;
      o_ack_b <= !(hit && !o_cs_b);
    end
  end

endmodule

// File: pll_clock_mode_select_asserts.sv
`timescale 1ns/1ps
`include "pll_clock_mode_select_defines.svh"

module pll_clock_mode_select_asserts (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic I_RESET_PIN_B,
  input wire logic I_HALT_PIN_B,
  input wire logic I_CLOCK_MODE_SELECT_I,
  input wire logic O_CLOCK_MODE_SELECT_OE,
  input wire logic O_PORT_A_BIT_TWELVE_IN,
  input wire logic I_CRYSTAL_CLOCK_INPUT,
  input wire logic O_CRYSTAL_DRIVE_OUTPUT,
  input wire logic I_PLL_CLOCK,
  input wire logic O_PLL_ENABLE,
  input wire logic [`MULT_W-1:0] O_MULTIPLICATION_FACTOR,
  input wire logic O_SYSTEM_CLOCK_OUTPUT,
  input wire logic O_SYSTEM_CLOCK_OE,
  input wire logic [`DRIVE_W-1:0] O_SYSTEM_CLOCK_DRIVE,
  input wire logic O_CORE_CLOCK,
  input wire logic O_COMMUNICATION_PROCESSOR_CLOCK,
  input wire logic O_INTEGRATION_CLOCK,
  input wire logic I_INT_AS,
  input wire logic O_EXT_AS_B,
  input wire logic I_EXT_AS_B,
  input wire logic O_SEEN_VALID,
  input wire logic O_CHIP_SELECT_B,
  input wire logic O_TRANSFER_ACKNOWLEDGE_B
);
  // high when no total reset is requested on the pins
  wire logic total_b = I_RESET_PIN_B | I_HALT_PIN_B;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);

  // configuration settles a few cycles after total reset ends
  sequence cfg_quiet;
    total_b [*6];
  endsequence

  chk_cfg_held: assert property (cfg_quiet |->
    $stable(O_PLL_ENABLE))
    else $error("pll enable moved outside total reset");
  chk_bypass_factor: assert property (cfg_quiet |->
    O_PLL_ENABLE || O_MULTIPLICATION_FACTOR == `MULT_BYPASS)
    else $error("bypass factor not one");
  chk_core_source: assert property (cfg_quiet |-> O_CORE_CLOCK ==
    $past(O_PLL_ENABLE ? I_PLL_CLOCK : I_CRYSTAL_CLOCK_INPUT))
    else $error("core clock source wrong");
  chk_clocks_tied: assert property (O_CORE_CLOCK ==
    O_COMMUNICATION_PROCESSOR_CLOCK && O_CORE_CLOCK == O_INTEGRATION_CLOCK)
    else $error("internal clocks differ");
  chk_osc_inverse: assert property ($past(I_RST_B) |->
    O_CRYSTAL_DRIVE_OUTPUT == !$past(I_CRYSTAL_CLOCK_INPUT))
    else $error("oscillator output not inverse");
  chk_drive_off: assert property (
    $past(O_SYSTEM_CLOCK_DRIVE) == 2'h0 && O_SYSTEM_CLOCK_DRIVE == 2'h0 |->
    !O_SYSTEM_CLOCK_OE && !O_SYSTEM_CLOCK_OUTPUT)
    else $error("clock output active while off");
  chk_mode_pin_in: assert property (!total_b |=>
    !O_CLOCK_MODE_SELECT_OE)
    else $error("mode pin driven in total reset");
  chk_port_follow: assert property ($past(I_RST_B) |->
    O_PORT_A_BIT_TWELVE_IN == $past(I_CLOCK_MODE_SELECT_I))
    else $error("port bit does not follow pin");
  chk_as_mirror: assert property ($past(I_RST_B) &&
    !$past(I_INT_AS) |-> O_EXT_AS_B)
    else $error("external strobe without access");
  chk_seen_valid: assert property ($past(I_RST_B) |->
    O_SEEN_VALID == !$past(I_EXT_AS_B))
    else $error("external access not seen");
  chk_ack_after_cs: assert property ($fell(O_CHIP_SELECT_B) |=>
    !O_TRANSFER_ACKNOWLEDGE_B && !O_CHIP_SELECT_B)
    else $error("acknowledge late");
endmodule

bind pll_clock_mode_select pll_clock_mode_select_asserts u_chk (.*);

// File: clock_source_model.sv
`timescale 1ns/1ps

module clock_source_model (
  input wire logic i_clk,
  input wire logic i_slow,
  output logic o_crystal,
  output logic o_synth
);
  int unsigned cnt_q;

  initial begin
    cnt_q = 0;
    o_crystal = 1'b0;
    o_synth = 1'b0;
  end

  // an oscillator runs free, so no idle state between uses
  always @(posedge i_clk) begin
    o_synth <= ~o_synth;
    cnt_q <= cnt_q + 1;
    if (cnt_q >= (i_slow ? 7 : 1)) begin
      cnt_q <= 0;
      o_crystal <= ~o_crystal;
    end
  end
endmodule

// File: pll_clock_mode_select_tb.sv
`timescale 1ns/1ps
`include "pll_clock_mode_select_defines.svh"

module pll_clock_mode_select_tb;
  logic I_MCLK, I_RST_B, I_WR, I_RD, I_PLL_SUPPLY_STRAP;
  logic I_RESET_PIN_B, I_HALT_PIN_B, I_CORE_DISABLE_MODE, I_INT_AS;
  logic I_PORT_A_BIT_TWELVE_OUT, I_PORT_A_BIT_TWELVE_OE, I_EXT_AS_B;
  logic [`REG_ADDR_W-1:0] I_ADDR;
  logic [`REG_DATA_W-1:0] I_WDATA, O_RDATA;
  logic [`EXT_ADDR_W-1:0] I_INT_ADDR, I_EXT_ADDR, O_EXT_ADDR, O_SEEN_ADDR;
  logic [`MULT_W-1:0] O_MULTIPLICATION_FACTOR;
  logic [`DRIVE_W-1:0] O_SYSTEM_CLOCK_DRIVE;
  logic O_CLOCK_MODE_SELECT_O, O_CLOCK_MODE_SELECT_OE, O_PORT_A_BIT_TWELVE_IN;
  logic O_CRYSTAL_DRIVE_OUTPUT, O_PLL_ENABLE, O_SYSTEM_CLOCK_OUTPUT;
  logic O_SYSTEM_CLOCK_OE, O_CORE_CLOCK, O_COMMUNICATION_PROCESSOR_CLOCK;
  logic O_INTEGRATION_CLOCK, O_EXT_AS_B, O_EXT_BUS_OE, O_SEEN_VALID;
  logic O_CHIP_SELECT_B, O_TRANSFER_ACKNOWLEDGE_B, mode_drv, slow;
  wire logic I_CLOCK_MODE_SELECT_I, I_CRYSTAL_CLOCK_INPUT, I_PLL_CLOCK;
  int fail_count = 0;
  int n_tests = 0;

  // the pin level: whoever has the enable wins
  assign I_CLOCK_MODE_SELECT_I = O_CLOCK_MODE_SELECT_OE ?
    O_CLOCK_MODE_SELECT_O : mode_drv;

  pll_clock_mode_select dut (.*);
  clock_source_model src (.i_clk(I_MCLK), .i_slow(slow),
    .o_crystal(I_CRYSTAL_CLOCK_INPUT), .o_synth(I_PLL_CLOCK));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_MCLK);
    I_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_MCLK);
    I_RD <= 1'b0;
    @(negedge I_MCLK);
    d = O_RDATA;
  endtask

  task automatic total_reset(input logic s, input logic m, input logic c);
    @(posedge I_MCLK);
    I_PLL_SUPPLY_STRAP <= s;
    I_CORE_DISABLE_MODE <= c;
    mode_drv <= m;
    I_RESET_PIN_B <= 1'b0;
    I_HALT_PIN_B <= 1'b0;
    repeat (10) @(posedge I_MCLK);
    I_RESET_PIN_B <= 1'b1;
    I_HALT_PIN_B <= 1'b1;
    repeat (2) @(posedge I_MCLK);
    mode_drv <= !m; // held past the 5 ns hold before moving
    repeat (6) @(negedge I_MCLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // internal clocks follow the selected source one cycle late
  task automatic t_clk(input logic sl);
    logic s;
    logic x;
    @(posedge I_MCLK);
    slow <= sl;
    @(negedge I_MCLK);
    s = O_PLL_ENABLE ? I_PLL_CLOCK : I_CRYSTAL_CLOCK_INPUT;
    x = I_CRYSTAL_CLOCK_INPUT;
    repeat (16) begin
      @(negedge I_MCLK);
      check(O_CORE_CLOCK, s);
      check({O_COMMUNICATION_PROCESSOR_CLOCK, O_INTEGRATION_CLOCK},
        {s, s});
      check(O_SYSTEM_CLOCK_OUTPUT, s);
      check(O_CRYSTAL_DRIVE_OUTPUT, !x);
      s = O_PLL_ENABLE ? I_PLL_CLOCK : I_CRYSTAL_CLOCK_INPUT;
      x = I_CRYSTAL_CLOCK_INPUT;
    end
  endtask

  // every strap and mode pin pair, then the pin moves after reset
  task automatic t_cfg();
    logic [31:0] d;
    logic [8:0] f;
    for (int i = 0; i < 4; i++) begin
      total_reset(i[1], i[0], 1'b0);
      f = i[1] ? (i[0] ? `MULT_KHZ_CRYSTAL : `MULT_MHZ_CRYSTAL) : `MULT_BYPASS;
      check(O_PLL_ENABLE, i[1]);
      check(O_MULTIPLICATION_FACTOR, f);
      reg_rd(`REG_STATUS, d);
      check(d, {28'h0, 2'h2, i[1] & i[0], i[1]});
      check(O_MULTIPLICATION_FACTOR, f);
      check(O_PORT_A_BIT_TWELVE_IN, !i[0]);
      t_clk(i[0]);
    end
  endtask

  // all drive settings, a hole in the map, a factor rewrite
  task automatic t_drive();
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      reg_wr(`REG_CLK_CTRL, k);
      reg_rd(`REG_CLK_CTRL, d);
      check(d, k);
      check(O_SYSTEM_CLOCK_DRIVE, k[1:0]);
      check(O_SYSTEM_CLOCK_OE, k != 0);
    end
    reg_rd(8'hfc, d);
    check(d, 32'h0);
    reg_wr(`REG_MULT, 32'h10);
    reg_rd(`REG_MULT, d);
    check(d, 32'h10);
    check(O_MULTIPLICATION_FACTOR, 9'h010);
  endtask

  // bus mirror, port drive of the pin, chip select in core-off mode
  task automatic t_bus();
    total_reset(1'b1, 1'b0, 1'b0);
    @(posedge I_MCLK);
    I_INT_AS <= 1'b1;
    I_INT_ADDR <= 19'h12345;
    I_PORT_A_BIT_TWELVE_OE <= 1'b1;
    I_PORT_A_BIT_TWELVE_OUT <= 1'b1;
    @(posedge I_MCLK);
    I_INT_AS <= 1'b0;
    @(negedge I_MCLK);
    check(O_EXT_AS_B, 1'b0);
    check(O_EXT_ADDR, 19'h12345);
    @(negedge I_MCLK);
    check(O_CLOCK_MODE_SELECT_OE, 1'b1);
    check(O_CLOCK_MODE_SELECT_O, 1'b1);
    check(O_EXT_BUS_OE, 1'b1);
    @(posedge I_MCLK);
    I_PORT_A_BIT_TWELVE_OE <= 1'b0;
    // a software drive setting must lose to the next total reset
    reg_wr(`REG_CLK_CTRL, 32'h1);
    total_reset(1'b1, 1'b0, 1'b1);
    check(O_SYSTEM_CLOCK_DRIVE, `DRIVE_RESET);
    check(O_EXT_BUS_OE, 1'b0);
    reg_wr(`REG_CS_BASE, 32'h40000);
    reg_wr(`REG_CS_MASK, 32'h70000);
    reg_wr(`REG_CS_CTRL, 32'h1);
    for (int h = 0; h < 2; h++) begin
      @(posedge I_MCLK);
      I_EXT_AS_B <= 1'b0;
      I_EXT_ADDR <= h ? 19'h31234 : 19'h41234;
      @(posedge I_MCLK);
      @(negedge I_MCLK);
      check(O_SEEN_VALID, 1'b1);
      check(O_SEEN_ADDR, h ? 19'h31234 : 19'h41234);
      check(O_CHIP_SELECT_B, h[0]);
      @(negedge I_MCLK);
      check(O_TRANSFER_ACKNOWLEDGE_B, h[0]);
      @(posedge I_MCLK);
      I_EXT_AS_B <= 1'b1;
      repeat (2) @(negedge I_MCLK);
      check(O_CHIP_SELECT_B, 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // free-running system clock
  initial begin
    I_MCLK = 1'b0;
    forever #5 I_MCLK = ~I_MCLK;
  end

  // whole run is about 230 cycles, so 20000 means a hang
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  // main sequence
  initial begin
    {I_RST_B, I_WR, I_RD, I_PLL_SUPPLY_STRAP, I_INT_AS} = 5'h0;
    {I_RESET_PIN_B, I_HALT_PIN_B, I_EXT_AS_B} = 3'h7;
    {I_CORE_DISABLE_MODE, I_PORT_A_BIT_TWELVE_OUT} = 2'h0;
    {I_PORT_A_BIT_TWELVE_OE, mode_drv, slow} = 3'h0;
    I_ADDR = 8'h00;
    I_WDATA = 32'h0;
    I_INT_ADDR = 19'h0;
    I_EXT_ADDR = 19'h0;
    repeat (2) @(posedge I_MCLK);
    I_RST_B <= 1'b1;
    repeat (3) @(negedge I_MCLK);
    check(O_PLL_ENABLE, 1'b0);
    check(O_MULTIPLICATION_FACTOR, `MULT_BYPASS);
    t_cfg();
    t_drive();
    t_bus();
    stop_test();
  end
endmodule
